/* logic/sfr_readout.sv */
// sample store, status flags and register read port of the sensor
// assumes samples, mode and reads come from logic on the same clock;
// the register read port sits behind the serial bus slave
import sfr_pkg::*;

module sfr_readout
  import sfr_pkg::*;
#(
  parameter int STORE_DEPTH = SFR_STORE_DEPTH,
  parameter int INBUF_DEPTH = SFR_INBUF_DEPTH
)(
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    sample_valid,
  output logic                         sample_ready,
  input  wire logic [SFR_PRESS_W-1:0]  sample_press,
  input  wire logic [SFR_TEMP_W-1:0]   sample_temp,
  input  wire logic [1:0]              queue_mode,
  input  wire logic [5:0]              queue_level_threshold,
  input  wire logic                    active_mode,
  input  wire logic [7:0]              nvm_ident,
  input  wire logic                    nvm_ident_valid,
  input  wire logic                    reg_read,
  input  wire logic [7:0]              reg_addr,
  output logic      [7:0]              reg_rdata,
  output logic                         fifo_event_clear,
  output logic                         queue_overflow_flag,
  output logic                         queue_level_flag,
  output logic      [5:0]              queue_sample_count
);
  localparam int PW = $clog2(STORE_DEPTH);

  // ----------------------------------------------------------------
  // input buffer and temperature change
  // ----------------------------------------------------------------
  logic                    buf_valid, drain_ready, acc;
  logic [SFR_SAMPLE_W-1:0] buf_data;
  logic [SFR_TEMP_W-1:0]   tchg;
  logic                    flush, enabled;
  logic                    active_q;

  sfr_inbuf #(.WIDTH(SFR_SAMPLE_W), .DEPTH(INBUF_DEPTH)) u_inbuf (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({sample_press, sample_temp}),
    .out_valid (buf_valid),
    .out_ready (drain_ready),
    .out_data  (buf_data)
  );

  // mode off still drains so change and live data keep updating; an
  // activation flush holds the buffer one cycle so no sample is lost
  assign drain_ready = ~(flush & enabled);
  assign acc         = buf_valid & drain_ready;

  sfr_tchg u_tchg (
    .clock             (clock),
    .reset_n           (reset_n),
    .sample_valid      (acc),
    .sample_temp       (buf_data[SFR_TEMP_W-1:0]),
    .temp_change_value (tchg)
  );

  // ----------------------------------------------------------------
  // store control
  // ----------------------------------------------------------------
  logic [SFR_SAMPLE_W-1:0] store_q [STORE_DEPTH];
  logic [PW-1:0]           wr_q, wr_d, rd_q, rd_d;
  logic [5:0]              cnt_q, cnt_d;
  logic [2:0]              byte_q, byte_d;
  logic                    ovf_q, ovf_d, lvl_q, lvl_d;
  logic                    full, store_push, drop, pop_read, port_hit;
  logic [SFR_SAMPLE_W-1:0] oldest;

  assign enabled = (queue_mode == SFR_MODE_CIRC) || (queue_mode == SFR_MODE_STOP);
  assign flush   = ~enabled | (active_mode & ~active_q);
  assign full    = (cnt_q == SFR_STORE_FULL);
  assign oldest  = store_q[rd_q];

  always_comb
  begin
    port_hit   = reg_read && ((reg_addr == SFR_ADDR_QPORT) ||
                 (enabled && reg_addr == SFR_ADDR_PRESS_HIGH));
    // stop mode refuses when full, circular overwrites the oldest
    store_push = acc && enabled && (!full || queue_mode == SFR_MODE_CIRC);
    pop_read   = port_hit && (cnt_q != '0) && (byte_q == SFR_BYTE_LAST);
    drop       = store_push && full && !pop_read;
    wr_d       = wr_q;
    rd_d       = rd_q;
    cnt_d      = cnt_q;
    byte_d     = byte_q;
    if (flush)
    begin
      wr_d   = '0;
      rd_d   = '0;
      cnt_d  = '0;
      byte_d = '0;
    end
    else
    begin
      if (store_push)
        wr_d = PW'(wr_q + 1'b1);
      if (pop_read || drop)
        rd_d = PW'(rd_q + 1'b1);
      cnt_d = cnt_q + 6'(store_push) - 6'(pop_read | drop);
      if (pop_read || drop)
        byte_d = '0;
      else if (port_hit && cnt_q != '0)
        byte_d = byte_q + 3'h1;
    end
    ovf_d = !flush && ((acc && enabled && full) ||
            (ovf_q && cnt_d == SFR_STORE_FULL));
    lvl_d = !flush && (queue_level_threshold != '0) &&
            (cnt_d > queue_level_threshold);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      byte_q   <= '0;
      ovf_q    <= 1'b0;
      lvl_q    <= 1'b0;
      active_q <= 1'b0;
    end
    else
    begin
      wr_q     <= wr_d;
      rd_q     <= rd_d;
      cnt_q    <= cnt_d;
      byte_q   <= byte_d;
      ovf_q    <= ovf_d;
      lvl_q    <= lvl_d;
      active_q <= active_mode;
    end
  end

  always_ff @(posedge clock)
  begin
    if (store_push)
      store_q[wr_q] <= buf_data;
  end

  // ----------------------------------------------------------------
  // live data, identifier and read data
  // ----------------------------------------------------------------
  logic [SFR_SAMPLE_W-1:0] live_q, live_d;
  logic [7:0]              id_q, id_d, rdata_q, rdata_d;
  logic                    evt_q, evt_d;

  always_comb
  begin
    live_d  = acc ? buf_data : live_q;
    // identifier comes only from the nonvolatile load
    id_d    = nvm_ident_valid ? nvm_ident : id_q;
    evt_d   = reg_read && (reg_addr == SFR_ADDR_QSTATUS);
    rdata_d = rdata_q;
    if (reg_read)
    begin
      rdata_d = SFR_BYTE_ZERO;
      if (port_hit)
      begin
        if (cnt_q != '0)
        begin
          case (byte_q)
            3'h0:    rdata_d = oldest[31:24];
            3'h1:    rdata_d = oldest[23:16];
            3'h2:    rdata_d = {oldest[15:12], 4'h0};
            3'h3:    rdata_d = oldest[11:4];
            default: rdata_d = {oldest[3:0], 4'h0};
          endcase
        end
      end
      else if (reg_addr >= SFR_ADDR_PRESS_HIGH && reg_addr <= SFR_ADDR_TEMP_LOW)
      begin
        if (!enabled)
        begin
          case (reg_addr)
            8'h01:   rdata_d = live_q[31:24];
            8'h02:   rdata_d = live_q[23:16];
            8'h03:   rdata_d = {live_q[15:12], 4'h0};
            8'h04:   rdata_d = live_q[11:4];
            default: rdata_d = {live_q[3:0], 4'h0};
          endcase
        end
      end
      else
      begin
        case (reg_addr)
          SFR_ADDR_TCHG_HIGH: rdata_d = tchg[11:4];
          SFR_ADDR_TCHG_LOW:  rdata_d = {tchg[3:0], 4'h0};
          SFR_ADDR_PART_ID:   rdata_d = id_q;
          SFR_ADDR_QSTATUS:   rdata_d = {ovf_q, lvl_q, cnt_q};
          default:            rdata_d = SFR_BYTE_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      live_q  <= '0;
      id_q    <= SFR_ID_RESET;
      evt_q   <= 1'b0;
      rdata_q <= SFR_BYTE_ZERO;
    end
    else
    begin
      live_q  <= live_d;
      id_q    <= id_d;
      evt_q   <= evt_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata           = rdata_q;
  assign fifo_event_clear    = evt_q;
  assign queue_overflow_flag = ovf_q;
  assign queue_level_flag    = lvl_q;
  assign queue_sample_count  = cnt_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  count_bound_a: assert property (cnt_q <= SFR_STORE_FULL)
    else $error("sample count above thirty-two");
  flush_clear_a: assert property (!enabled |=> cnt_q == '0 && !ovf_q && !lvl_q)
    else $error("disabled store not cleared");
  level_cause_a: assert property (lvl_q |->
    $past(queue_level_threshold) != '0 && cnt_q > $past(queue_level_threshold))
    else $error("level flag without count above threshold");
  ovf_hold_a: assert property (ovf_q && full && !flush && !pop_read |=> ovf_q)
    else $error("overflow flag dropped while still full");
  pop_count_a: assert property (pop_read && !store_push && !flush |=>
    cnt_q == $past(cnt_q) - 6'h01)
    else $error("sample read out did not decrement count");
  empty_zero_a: assert property (port_hit && cnt_q == '0 |=> reg_rdata == 8'h00)
    else $error("empty store read returned nonzero");
  live_zero_a: assert property (reg_read && enabled &&
    reg_addr >= SFR_ADDR_PRESS_MID && reg_addr <= SFR_ADDR_TEMP_LOW |=> reg_rdata == 8'h00)
    else $error("live data address not zero while store enabled");
  evt_clear_a: assert property (reg_read && reg_addr == SFR_ADDR_QSTATUS |=>
    fifo_event_clear)
    else $error("status read did not clear event bit");
  accum_go_a: assert property (store_push && !flush |=> cnt_q >= $past(cnt_q))
    else $error("accepted sample lost from count");
  id_read_a: assert property (reg_read && reg_addr == SFR_ADDR_PART_ID |=>
    reg_rdata == $past(id_q))
    else $error("identifier read mismatch");
  ovf_set_a: assert property (acc && enabled && full && !flush |=> ovf_q)
    else $error("overflow flag not set on sample at full store");
  level_off_a: assert property (queue_level_threshold == '0 |=> !lvl_q)
    else $error("level flag set with zero threshold");
  byte_bound_a: assert property (byte_q <= SFR_BYTE_LAST)
    else $error("byte index beyond last byte of sample");
  push_count_a: assert property (store_push && !full && !pop_read && !flush |=>
    cnt_q == $past(cnt_q) + 6'h01)
    else $error("stored sample not counted");
  evt_quiet_a: assert property (!(reg_read && reg_addr == SFR_ADDR_QSTATUS) |=>
    !fifo_event_clear)
    else $error("event clear without status read");
  stop_keep_a: assert property (acc && queue_mode == SFR_MODE_STOP && full &&
    !pop_read |=> cnt_q == SFR_STORE_FULL)
    else $error("stop mode took a sample into a full store");
  port_addr_a: assert property (port_hit && reg_addr == SFR_ADDR_PRESS_HIGH &&
    cnt_q != '0 && byte_q == '0 |=> reg_rdata == $past(oldest[31:24]))
    else $error("first byte at the shared address is not the oldest pressure high byte");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  circ_over_c: cover property (drop);
  stop_refuse_c: cover property (acc && queue_mode == SFR_MODE_STOP && full);
  sample_out_c: cover property (pop_read ##1 lvl_q == 1'b0);
  wrap_read_c: cover property (pop_read && store_push);
  empty_read_c: cover property (port_hit && cnt_q == '0);
endmodule

/* pkg/sfr_pkg.sv */
// constants shared by the sample store readout logic
// assumes one 25 MHz clock domain and an active low asynchronous reset
package sfr_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_ADDR_PRESS_HIGH = 8'h01;
  localparam logic [7:0] SFR_ADDR_PRESS_MID  = 8'h02;
  localparam logic [7:0] SFR_ADDR_TEMP_LOW   = 8'h05;
  localparam logic [7:0] SFR_ADDR_TCHG_HIGH  = 8'h0A;
  localparam logic [7:0] SFR_ADDR_TCHG_LOW   = 8'h0B;
  localparam logic [7:0] SFR_ADDR_PART_ID    = 8'h0C;
  localparam logic [7:0] SFR_ADDR_QSTATUS    = 8'h0D;
  localparam logic [7:0] SFR_ADDR_QPORT      = 8'h0E;

  // ----------------------------------------------------------------
  // fields, modes and sizes
  // ----------------------------------------------------------------
  localparam int         SFR_STAT_OVF_BIT = 7;
  localparam int         SFR_STAT_LVL_BIT = 6;
  localparam logic [1:0] SFR_MODE_OFF     = 2'h0;
  localparam logic [1:0] SFR_MODE_CIRC    = 2'h1;
  localparam logic [1:0] SFR_MODE_STOP    = 2'h2;
  localparam int         SFR_PRESS_W      = 20;
  localparam int         SFR_TEMP_W       = 12;
  localparam int         SFR_SAMPLE_W     = 32;
  localparam int         SFR_STORE_DEPTH  = 32;
  localparam int         SFR_INBUF_DEPTH  = 4;
  localparam logic [5:0] SFR_STORE_FULL   = 6'h20;
  localparam logic [2:0] SFR_BYTE_LAST    = 3'h4;
  localparam logic [7:0] SFR_BYTE_ZERO    = 8'h00;
  localparam logic [7:0] SFR_ID_RESET     = 8'h00;

endpackage

/* logic/sfr_inbuf.sv */
// small sample buffer with valid and ready on both sides
// assumes both sides on the same clock
module sfr_inbuf
  import sfr_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
)(
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    wr_d  = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
    rd_d  = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule

/* logic/sfr_tchg.sv */
// temperature change tracker: newest sample minus the one before
// assumes sample_valid is a one-cycle pulse per sample
module sfr_tchg
  import sfr_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  sample_valid,
  input  wire logic [SFR_TEMP_W-1:0] sample_temp,
  output logic      [SFR_TEMP_W-1:0] temp_change_value
);
  logic [SFR_TEMP_W-1:0] prev_q, prev_d, chg_q, chg_d;
  logic                  seen_q, seen_d;

  always_comb
  begin
    prev_d = prev_q;
    chg_d  = chg_q;
    seen_d = seen_q;
    if (sample_valid)
    begin
      prev_d = sample_temp;
      seen_d = 1'b1;
      // first sample has no predecessor, report no change
      chg_d  = seen_q ? SFR_TEMP_W'(sample_temp - prev_q) : '0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q <= '0;
      chg_q  <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      chg_q  <= chg_d;
      seen_q <= seen_d;
    end
  end

  assign temp_change_value = chg_q;

  tchg_diff_a: assert property (@(posedge clock) disable iff (!reset_n)
    sample_valid && seen_q |=>
      temp_change_value == SFR_TEMP_W'($past(sample_temp) - $past(prev_q)))
    else $error("temperature change not newest minus previous");
endmodule

/* dv/sfr_host_model.sv */
// host side of the register read port: one strobe per byte read
// assumes the caller enters rd just after a rising edge of clock
module sfr_host_model
  import sfr_pkg::*;
(
  input  wire logic       clock,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       fifo_event_clear
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_read = 1'b0;
    reg_addr = 8'h00;
  end

  // strobe held one cycle, data taken just after the edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic c);
    @(posedge clock);
    #1;
    reg_read = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_read = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    c = fifo_event_clear;
  endtask
endmodule

/* dv/tb_sample_fifo_readout_status.sv */
// self-checking bench of the sample store readout
// assumes the host model drives the read port; bench drives samples
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb_sample_fifo_readout_status
  import sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ID_CODE = 8'h3A; // arbitrary identifier value
  logic        clock, reset_n, sample_valid, sample_ready, active_mode;
  logic [19:0] sample_press;
  logic [11:0] sample_temp, last_t, tchg_e;
  logic [1:0]  queue_mode;
  logic [5:0]  queue_level_threshold, queue_sample_count;
  logic [7:0]  nvm_ident, reg_addr, reg_rdata, got;
  logic        nvm_ident_valid, reg_read, fifo_event_clear, clr, have_t, ovf_e;
  logic        queue_overflow_flag, queue_level_flag;
  logic [31:0] exp_q[$];
  int          failures, compares, cycles;

  sfr_readout dut (.clock(clock), .reset_n(reset_n), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_press(sample_press), .sample_temp(sample_temp),
    .queue_mode(queue_mode), .queue_level_threshold(queue_level_threshold),
    .active_mode(active_mode), .nvm_ident(nvm_ident), .nvm_ident_valid(nvm_ident_valid),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .fifo_event_clear(fifo_event_clear), .queue_overflow_flag(queue_overflow_flag),
    .queue_level_flag(queue_level_flag), .queue_sample_count(queue_sample_count));
  sfr_host_model host (.clock(clock), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .fifo_event_clear(fifo_event_clear));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sbyte(logic [31:0] s, int i);
    case (i)
      0: return s[31:24];
      1: return s[23:16];
      2: return {s[15:12], 4'h0};
      3: return s[11:4];
      default: return {s[3:0], 4'h0};
    endcase
  endfunction

  function automatic logic [7:0] stat_e(logic o, logic [5:0] t, int n);
    logic [5:0] c;
    c = 6'(n);
    return {o, (t != 6'h00) && (c > t), c};
  endfunction

  task automatic stop_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic push(logic [31:0] s);
    sample_press = s[31:12];
    sample_temp  = s[11:0];
    sample_valid = 1'b1;
    // ready is judged once settled, before the edge that takes the sample
    while (sample_ready !== 1'b1)
    begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    sample_valid = 1'b0;
    sample_press = ~s[31:12];
    if (queue_mode == SFR_MODE_CIRC || queue_mode == SFR_MODE_STOP)
    begin
      if (exp_q.size() == 32)
      begin
        ovf_e = 1'b1;
        if (queue_mode == SFR_MODE_CIRC)
        begin
          void'(exp_q.pop_front());
          exp_q.push_back(s);
        end
      end
      else
        exp_q.push_back(s);
    end
    tchg_e = have_t ? s[11:0] - last_t : 12'h000;
    last_t = s[11:0];
    have_t = 1'b1;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic chk_state();
    logic [7:0] st;
    st = stat_e(ovf_e, queue_level_threshold, exp_q.size());
    host.rd(SFR_ADDR_QSTATUS, got, clr);
    `CHK("status", st, got)
    `CHK("overflow flag", st[7], queue_overflow_flag)
    `CHK("level flag", st[6], queue_level_flag)
    `CHK("event clear", 1'b1, clr)
    `CHK("count port", 6'(exp_q.size()), queue_sample_count)
  endtask

  task automatic chk_tchg();
    host.rd(SFR_ADDR_TCHG_HIGH, got, clr);
    `CHK("change high", tchg_e[11:4], got)
    `CHK("no event clear", 1'b0, clr)
    host.rd(SFR_ADDR_TCHG_LOW, got, clr);
    `CHK("change low", {tchg_e[3:0], 4'h0}, got)
  endtask

  task automatic pop_sample(logic [7:0] a);
    for (int i = 0; i < 5; i++)
    begin
      host.rd(a, got, clr);
      if (exp_q.size() == 0)
        `CHK("empty byte", SFR_BYTE_ZERO, got)
      else
        `CHK("port byte", sbyte(exp_q[0], i), got)
    end
    if (exp_q.size() > 0)
      void'(exp_q.pop_front());
    if (exp_q.size() < 32)
      ovf_e = 1'b0;
  endtask

  task automatic set_mode(logic [1:0] m);
    queue_mode = m;
    if (m == SFR_MODE_OFF)
    begin
      exp_q.delete();
      ovf_e = 1'b0;
    end
    repeat (2) @(posedge clock);
    #1;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 8000)
    begin
      failures++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] zaddr[6];
    zaddr = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h3F};
    {sample_valid, sample_press, sample_temp, queue_mode} = '0;
    {queue_level_threshold, nvm_ident, nvm_ident_valid} = '0;
    {have_t, ovf_e, last_t, tchg_e} = '0;
    active_mode = 1'b1;
    failures = 0;
    compares = 0;
    cycles = 0;
    void'($urandom(23089));
    reset_n = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    foreach (zaddr[i])
    begin
      host.rd(zaddr[i], got, clr);
      `CHK("reset value", 8'h00, got)
    end
    nvm_ident = ID_CODE;
    nvm_ident_valid = 1'b1;
    @(posedge clock);
    #1;
    nvm_ident_valid = 1'b0;
    nvm_ident = 8'h00;
    host.rd(SFR_ADDR_PART_ID, got, clr);
    `CHK("identifier", ID_CODE, got)
    push($urandom);
    push($urandom);
    chk_tchg();
    host.rd(SFR_ADDR_PRESS_HIGH, got, clr);
    `CHK("live high", sample_press[19:12] ^ 8'hFF, got)
    chk_state();
    queue_level_threshold = 6'h03;
    set_mode(SFR_MODE_CIRC);
    repeat (5) push($urandom);
    chk_state();
    host.rd(SFR_ADDR_PRESS_MID, got, clr);
    `CHK("other live", 8'h00, got)
    host.rd(SFR_ADDR_TEMP_LOW, got, clr);
    `CHK("other live", 8'h00, got)
    chk_tchg();
    pop_sample(SFR_ADDR_PRESS_HIGH);
    fork
      pop_sample(SFR_ADDR_QPORT);
      push({20'hFFFFF, 12'h800});
    join
    chk_state();
    while (exp_q.size() > 0)
      pop_sample(SFR_ADDR_QPORT);
    pop_sample(SFR_ADDR_QPORT);
    chk_state();
    repeat (34) push($urandom);
    chk_state();
    pop_sample(SFR_ADDR_PRESS_HIGH);
    chk_state();
    active_mode = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    active_mode = 1'b1;
    exp_q.delete();
    repeat (2) @(posedge clock);
    #1;
    chk_state();
    set_mode(SFR_MODE_OFF);
    set_mode(SFR_MODE_STOP);
    queue_level_threshold = 6'h00;
    repeat (33) push($urandom);
    chk_state();
    pop_sample(SFR_ADDR_QPORT);
    chk_state();
    set_mode(SFR_MODE_OFF);
    chk_state();
    set_mode(2'h3);
    host.rd(SFR_ADDR_PRESS_HIGH, got, clr);
    `CHK("unused mode live", sample_press[19:12] ^ 8'hFF, got)
    stop_test();
  end
endmodule
